// [common/dmpl_pkg.sv]
// Package: constants and carriers for the synthesizer divider loader
package dmpl_pkg;
    localparam int REF_W       = 14;    // Reference divider width
    localparam int MAIN_W      = 10;    // Main feedback counter width
    localparam int SWAL_W      = 7;     // Swallow counter width
    localparam int WORD_W      = REF_W + MAIN_W + SWAL_W + 1;
    localparam int CTRL_POS    = 0;     // Control bit, last shifted
    localparam int SWAL_POS    = 1;
    localparam int MAIN_POS    = SWAL_POS + SWAL_W;
    localparam int REF_POS     = MAIN_POS + MAIN_W;
    localparam logic [2:0] SEL_CODE = 3'h2;  // Pattern 010 on lines 0,1,2
    localparam int PRESC_LO    = 128;   // Prescaler low modulus
    localparam int PRESC_HI    = 129;   // Prescaler high modulus
    localparam real REF_MHZ    = 12.8;  // Nominal reference input
    localparam logic [REF_W-1:0]  REF_RST  = 14'h0800;
    localparam logic [MAIN_W-1:0] MAIN_RST = 10'h0010;
    localparam logic [SWAL_W-1:0] SWAL_RST = 7'h00;
    localparam int LOCK_CNT_W  = 4;     // Lock qualifier counter width
    localparam logic [3:0] LOCK_GOOD = 4'h4;  // Matched pulses to lock

    // Active division ratios
    typedef struct packed {
        logic [REF_W-1:0]  ref_div;
        logic [MAIN_W-1:0] main_div;
        logic [SWAL_W-1:0] swal_div;
    } dmpl_ratio_t;

    // Serial load port pins
    typedef struct packed {
        logic       sclk;
        logic       sdata;
        logic       enable;
        logic [2:0] select_code_lines;
    } dmpl_serial_t;
endpackage

// [rtl/dmpl_loader.sv]
// Divider loader, reference and dual-modulus feedback counters, lock
`timescale 1ns/100ps

module dmpl_loader (
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_n,
    input  wire logic                 i_ce,
    input  wire dmpl_pkg::dmpl_serial_t i_ser,
    input  wire logic                 i_reference_input,
    input  wire logic                 i_presc_fb,
    input  wire logic                 i_int_ref_sel,
    output logic                      o_modulus_hi,
    output logic                      o_reference_compare_freq,
    output logic                      o_fb_compare_freq,
    output logic                      o_lock_indication,
    output logic                      o_int_osc_en,
    output dmpl_pkg::dmpl_ratio_t     o_ratio
);
    localparam int W = dmpl_pkg::WORD_W;

    ////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisers
    logic [1:0] rst_sync_reg;
    logic       rst_n;
    logic [6:0] pin_s1_reg;
    logic [6:0] pin_s2_reg;
    logic [6:0] pin_s3_reg;
    logic [6:0] pins;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    assign pins = {i_ser.sclk, i_ser.sdata, i_ser.enable,
                   i_ser.select_code_lines, i_reference_input};

    // Two stages, third for edge finding
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_reg <= 7'h00;
            pin_s2_reg <= 7'h00;
            pin_s3_reg <= 7'h00;
        end else if (i_ce) begin
            pin_s1_reg <= pins;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
        end
    end

    logic       sel_ok;
    logic       sclk_rise;
    logic       en_hi;
    logic       en_rise;
    logic       sdata;
    logic       refin_rise;
    logic       fb_s1_reg;
    logic       fb_s2_reg;
    logic       fb_s3_reg;
    logic       fb_rise;

    assign sel_ok    = (pin_s2_reg[3:1] == dmpl_pkg::SEL_CODE);
    assign sclk_rise = sel_ok & pin_s2_reg[6] & ~pin_s3_reg[6];
    assign sdata     = pin_s2_reg[5];
    assign en_hi     = sel_ok & pin_s2_reg[4];
    assign en_rise   = en_hi & ~pin_s3_reg[4];
    assign refin_rise = pin_s2_reg[0] & ~pin_s3_reg[0];

    // Prescaler feedback synchroniser
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            fb_s1_reg <= 1'b0;
            fb_s2_reg <= 1'b0;
            fb_s3_reg <= 1'b0;
        end else if (i_ce) begin
            fb_s1_reg <= i_presc_fb;
            fb_s2_reg <= fb_s1_reg;
            fb_s3_reg <= fb_s2_reg;
        end
    end
    assign fb_rise = fb_s2_reg & ~fb_s3_reg;

    ////////////////////////////////////////////////////////////////////
    // Serial shift register and divider latches
    logic [W-1:0]          shift_reg;
    logic [W-1:0]          shift_next;
    dmpl_pkg::dmpl_ratio_t ratio_reg;
    dmpl_pkg::dmpl_ratio_t ratio_next;

    always_comb begin
        shift_next = shift_reg;
        ratio_next = ratio_reg;
        if (sclk_rise) begin
            shift_next = {shift_reg[W-2:0], sdata};
        end
        // Latch only with control bit set
        if (en_rise && shift_reg[dmpl_pkg::CTRL_POS]) begin
            ratio_next.ref_div  = shift_reg[dmpl_pkg::REF_POS +:
                                  dmpl_pkg::REF_W];
            ratio_next.main_div = shift_reg[dmpl_pkg::MAIN_POS +:
                                  dmpl_pkg::MAIN_W];
            ratio_next.swal_div = shift_reg[dmpl_pkg::SWAL_POS +:
                                  dmpl_pkg::SWAL_W];
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_reg <= '0;
            ratio_reg <= {dmpl_pkg::REF_RST, dmpl_pkg::MAIN_RST,
                          dmpl_pkg::SWAL_RST};
        end else if (i_ce) begin
            shift_reg <= shift_next;
            ratio_reg <= ratio_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Reference divider and dual-modulus feedback counters
    logic [dmpl_pkg::REF_W-1:0]  rcnt_reg, rcnt_next;
    logic [dmpl_pkg::MAIN_W-1:0] ncnt_reg, ncnt_next;
    logic [dmpl_pkg::SWAL_W-1:0] acnt_reg, acnt_next;
    logic fr_reg, fr_next, fv_reg, fv_next, mod_reg, mod_next;

    always_comb begin
        rcnt_next = rcnt_reg;
        ncnt_next = ncnt_reg;
        acnt_next = acnt_reg;
        fr_next   = 1'b0;
        fv_next   = 1'b0;
        mod_next  = (acnt_reg != '0);
        if (refin_rise) begin
            if (rcnt_reg <= 14'h0001) begin
                rcnt_next = ratio_reg.ref_div;
                fr_next   = 1'b1;
            end else begin
                rcnt_next = rcnt_reg - 14'h0001;
            end
        end
        if (fb_rise) begin
            if (acnt_reg != '0) begin
                acnt_next = acnt_reg - 7'h01;
            end
            if (ncnt_reg <= 10'h001) begin
                ncnt_next = ratio_reg.main_div;
                acnt_next = ratio_reg.swal_div;
                fv_next   = 1'b1;
            end else begin
                ncnt_next = ncnt_reg - 10'h001;
            end
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            rcnt_reg <= dmpl_pkg::REF_RST;
            ncnt_reg <= dmpl_pkg::MAIN_RST;
            acnt_reg <= dmpl_pkg::SWAL_RST;
            fr_reg   <= 1'b0;
            fv_reg   <= 1'b0;
            mod_reg  <= 1'b0;
        end else if (i_ce) begin
            rcnt_reg <= rcnt_next;
            ncnt_reg <= ncnt_next;
            acnt_reg <= acnt_next;
            fr_reg   <= fr_next;
            fv_reg   <= fv_next;
            mod_reg  <= mod_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Lock detector: reference and feedback pulses arrive in the same cycle when in phase
    logic [1:0] pend_reg, pend_next;   // [0] ref seen, [1] fb seen
    logic [3:0] good_reg, good_next;
    logic       lock_reg, lock_next;
    logic       intosc_reg;

    always_comb begin
        pend_next = pend_reg;
        good_next = good_reg;
        lock_next = lock_reg;
        if (fr_reg && fv_reg) begin
            pend_next = 2'h0;
            if (good_reg != dmpl_pkg::LOCK_GOOD) begin
                good_next = good_reg + 4'h1;
            end
        end else if ((fr_reg && pend_reg[0]) || (fv_reg && pend_reg[1])) begin
            pend_next = 2'h0;   // Two of one kind: out of lock
            good_next = 4'h0;
        end else if (fr_reg) begin
            pend_next = {pend_reg[1], 1'b1};
        end else if (fv_reg) begin
            pend_next = {1'b1, pend_reg[0]};
        end
        if (good_next == 4'h0) begin
            lock_next = 1'b0;
        end else if (good_next == dmpl_pkg::LOCK_GOOD) begin
            lock_next = 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_reg   <= 2'h0;
            good_reg   <= 4'h0;
            lock_reg   <= 1'b0;
            intosc_reg <= 1'b0;
        end else if (i_ce) begin
            pend_reg   <= pend_next;
            good_reg   <= good_next;
            lock_reg   <= lock_next;
            intosc_reg <= i_int_ref_sel;
        end
    end

    assign o_modulus_hi             = mod_reg;
    assign o_reference_compare_freq = fr_reg;
    assign o_fb_compare_freq        = fv_reg;
    assign o_lock_indication        = lock_reg;
    assign o_int_osc_en             = intosc_reg;
    assign o_ratio                  = ratio_reg;

    ////////////////////////////////////////////////////////////////////
    // Checks
    a_latch_ctrl: assert property (@(posedge i_clk) disable iff (!rst_n)
        (i_ce && en_rise && shift_reg[0]) |=> (o_ratio == $past(shift_reg[W-1:1])))
        else $error("latch did not load");
    a_no_latch: assert property (@(posedge i_clk) disable iff (!rst_n)
        (i_ce && !(en_rise && shift_reg[0])) |=> $stable(o_ratio))
        else $error("ratio changed without load");
    a_shift_in: assert property (@(posedge i_clk) disable iff (!rst_n)
        (i_ce && sclk_rise) |=> (shift_reg[0] == $past(sdata)))
        else $error("bit not shifted");
    a_sel_block: assert property (@(posedge i_clk) disable iff (!rst_n)
        (i_ce && !sel_ok) |=> $stable(shift_reg) && $stable(o_ratio))
        else $error("load passed with wrong select");
    a_mod_hi: assert property (@(posedge i_clk) disable iff (!rst_n)
        (i_ce && acnt_reg != '0) |=> o_modulus_hi)
        else $error("modulus not high");
    a_fv_reload: assert property (@(posedge i_clk) disable iff (!rst_n)
        (i_ce && fb_rise && ncnt_reg <= 10'h001) |=>
        (o_fb_compare_freq && ncnt_reg == $past(ratio_reg.main_div)))
        else $error("main counter reload wrong");
    a_fr_reload: assert property (@(posedge i_clk) disable iff (!rst_n)
        (i_ce && refin_rise && rcnt_reg <= 14'h0001) |=>
        o_reference_compare_freq)
        else $error("reference pulse missing");
    a_unlock: assert property (@(posedge i_clk) disable iff (!rst_n)
        (i_ce && fr_reg && !fv_reg && pend_reg[0]) |=> !o_lock_indication)
        else $error("lock held on mismatch");
endmodule

// [test/dmpl_ctrl_model.sv]
// System controller model that drives the serial load lines
`timescale 1ns/100ps
module dmpl_ctrl_model (
    output dmpl_pkg::dmpl_serial_t o_ser
);
    // Idle: link clock still, select lines off the device's code
    initial begin
        o_ser = '0;
        o_ser.select_code_lines = 3'h7;
    end

    // One frame: select, 32 bits MSB first, then an enable pulse
    task automatic load(input logic [31:0] word, input logic [2:0] sel);
        o_ser.select_code_lines = sel;
        for (int i = 31; i >= 0; i--) begin
            #160;
            o_ser.sclk  = 1'b0;
            o_ser.sdata = word[i];
            #160;
            o_ser.sclk  = 1'b1;
        end
        #160;
        o_ser.sclk  = 1'b0;
        o_ser.sdata = ~o_ser.sdata; // Released data line shows no stale bit
        #160;
        o_ser.enable = 1'b1;
        #320;
        o_ser.enable = 1'b0;
        #160;
        o_ser.select_code_lines = 3'h7;
    endtask
endmodule

// [test/testbench.sv]
// Testbench for serial loading, dividers, modulus control and lock
`timescale 1ns/100ps
module testbench;
    logic                   i_clk;
    logic                   i_rst_n;
    logic                   ce;
    logic                   ref_in;
    logic                   fb_in;
    logic                   fb_run;
    logic                   int_sel;
    logic                   mod_hi;
    logic                   fr;
    logic                   fv;
    logic                   lock;
    logic                   osc_en;
    dmpl_pkg::dmpl_serial_t ser;
    dmpl_pkg::dmpl_ratio_t  ratio;
    int                     num_errors;
    int                     compares;

    dmpl_ctrl_model ctrl (.o_ser(ser));
    dmpl_loader DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(ce),
        .i_ser(ser), .i_reference_input(ref_in), .i_presc_fb(fb_in),
        .i_int_ref_sel(int_sel), .o_modulus_hi(mod_hi),
        .o_reference_compare_freq(fr), .o_fb_compare_freq(fv),
        .o_lock_indication(lock), .o_int_osc_en(osc_en), .o_ratio(ratio));

    // System clock
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    // Reference and prescaler waveforms, fb a gated copy of ref
    initial begin
        ref_in = 1'b0;
        fb_in  = 1'b0;
        #22;
        forever begin
            #160;
            ref_in = ~ref_in;
            fb_in  = fb_run & ref_in;
        end
    end

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results;
        if (num_errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Send one frame and let the latch settle
    task automatic load(input logic [30:0] r, input logic [2:0] sel,
                        input logic c);
        ctrl.load({r, c}, sel);
        repeat (8) @(posedge i_clk);
        #2;
    endtask

    // Pin rises between two output pulses, and those seen with /129;
    // a running count only reloads on expiry, so allow a long first wait
    task automatic gap(input bit use_fb, output int edges, output int hi);
        logic pin;
        logic prev;
        int   k;
        int   seen;
        edges = 0;
        hi    = 0;
        seen  = 0;
        prev  = 1'b1;
        for (k = 0; k < 20000 && seen < 2; k++) begin
            @(posedge i_clk);
            pin = use_fb ? fb_in : ref_in;
            #2;
            if (seen == 1 && pin && !prev) begin
                edges++;
                if (mod_hi === 1'b1) hi++;
            end
            prev = pin;
            if ((use_fb ? fv : fr) === 1'b1) seen++;
        end
    endtask

    task automatic t_reset;
        check("ratio", ratio, {dmpl_pkg::REF_RST, dmpl_pkg::MAIN_RST,
              dmpl_pkg::SWAL_RST});
        check("lock", lock, 1'b0);
    endtask

    task automatic t_load;
        load({14'h3A5C, 10'h02C1, 7'h35}, 3'h2, 1'b1);
        check("ratio", ratio, {14'h3A5C, 10'h02C1, 7'h35});
        load({14'h0001, 10'h0001, 7'h01}, 3'h2, 1'b0);
        check("ratio ctrl0", ratio, {14'h3A5C, 10'h02C1, 7'h35});
        for (int s = 0; s < 8; s++) begin
            if (s != 2) begin
                load({14'h0002, 10'h0002, 7'h02}, s[2:0], 1'b1);
                check("ratio sel", ratio, {14'h3A5C, 10'h02C1, 7'h35});
            end
        end
    endtask

    task automatic t_div;
        int e;
        int h;
        fb_run = 1'b1;
        load({14'h0005, 10'h0003, 7'h02}, 3'h2, 1'b1);
        check("ratio", ratio, {14'h0005, 10'h0003, 7'h02});
        gap(1'b0, e, h);
        check("ref edges", e, 32'h0000_0005);
        gap(1'b1, e, h);
        check("fb edges", e, 32'h0000_0003);
        check("hi edges", h, 32'h0000_0002);
    endtask

    task automatic t_lock;
        load({14'h0001, 10'h0001, 7'h00}, 3'h2, 1'b1);
        repeat (100) @(posedge i_clk);
        #2;
        check("lock", lock, 1'b1);
        fb_run = 1'b0;
        repeat (30) @(posedge i_clk);
        #2;
        check("unlock", lock, 1'b0);
    endtask

    task automatic t_osc;
        int_sel = 1'b1;
        @(posedge i_clk);
        #2;
        check("osc on", osc_en, 1'b1);
        ce      = 1'b0;
        int_sel = 1'b0;
        repeat (2) @(posedge i_clk);
        #2;
        check("osc held", osc_en, 1'b1);
        ce = 1'b1;
        @(posedge i_clk);
        #2;
        check("osc off", osc_en, 1'b0);
    endtask

    // Main sequence
    initial begin
        num_errors = 0;
        compares   = 0;
        ce         = 1'b1;
        fb_run     = 1'b0;
        int_sel    = 1'b0;
        i_rst_n    = 1'b0;
        repeat (6) @(posedge i_clk);
        #2;
        i_rst_n = 1'b1;
        repeat (4) @(posedge i_clk);
        #2;
        t_reset;
        t_load;
        t_div;
        t_lock;
        t_osc;
        results;
    end

    // Watchdog, well beyond the ~17k cycles the tests need
    initial begin
        #1000000;
        num_errors++;
        results;
    end
endmodule
